//--- dv/scs_monitor.sv
// Purpose: Wire checks on the serial programming link
// Assumes: One clk per sclk level, one-clk strobe
// Notes: Sees the interface signals only
`timescale 1ns/1ns
module scs_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic strobe,
   input wire logic powerdown_tristate_n
);
   logic sclk_q_ff;
   logic [4:0] bits_ff;
   logic [4:0] nxt_bits;
   // Count shift clock rises since the last strobe
   always_comb begin
      nxt_bits = bits_ff;
      if (strobe) begin
         nxt_bits = 5'h00;
      end else if (sclk && !sclk_q_ff) begin
         nxt_bits = bits_ff + 5'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_q_ff <= 1'b0;
         bits_ff <= 5'h00;
      end else begin
         sclk_q_ff <= sclk;
         bits_ff <= nxt_bits;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // One high clk per bit, then the last fall carries the strobe
   sequence s_bit;
      $rose(sclk) ##1 $fell(sclk);
   endsequence
   sequence s_last;
      $fell(sclk) && bits_ff == 5'h18;
   endsequence
   a_strobe_quiet: assert property (strobe |-> !sclk)
      else $error("sclk high while strobe high");
   a_bit_shape: assert property ($rose(sclk) |-> s_bit)
      else $error("sclk high not one clk");
   a_data_setup: assert property ($rose(sclk) |-> $stable(sdata))
      else $error("sdata moved at sclk rise");
   a_count_cap: assert property (bits_ff <= 5'h18)
      else $error("more than 24 bits shifted");
   a_strobe_count: assert property ($rose(strobe) |-> bits_ff == 5'h18)
      else $error("strobe without 24 bits");
   a_last_strobe: assert property (s_last |-> strobe)
      else $error("no strobe after last bit");
   a_strobe_pulse: assert property ($rose(strobe) |=> !strobe && !sclk)
      else $error("strobe not a one clk pulse");
endmodule

//--- dv/tb.sv
// Purpose: Host and device ends joined, driven over AHB-Lite
// Assumes: Lock timer shortened to 20 clk
// Notes: Reference clock runs at clk/4
`timescale 1ns/1ns
module tb;
   import scs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic xtal = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic hready, mclk, moe, aclk, aoe, byp, pdn, lck, dty;
   logic [31:0] hrdata, rd;
   logic [6:0] inw;
   logic [8:0] fbw;
   logic [3:0] odr;
   logic [2:0] pst;
   logic [1:0] axs, xls;
   int error_cnt = 0;
   int tests_run = 0;
   scs_if lk ();
   // Free-running system and reference clocks
   always #20 clk = ~clk;
   always #80 xtal = ~xtal;
   scs_host u_scs_host (.clk(clk), .rst(rst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(), .hrdata(hrdata), .link(lk.host));
   scs_dev #(.LOCK_CYC(20)) u_scs_dev (.clk(clk), .rst(rst), .ce(1'b1), .link(lk.dev),
      .crystal_in_pin(xtal), .crystal_out_pin(), .main_clock_out(mclk), .main_clock_oe(moe),
      .aux_clock_out(aclk), .aux_clock_oe(aoe), .pll_bypass(byp), .powered_down(pdn),
      .pll_locked(lck), .input_divider_word(inw), .feedback_divider_word(fbw),
      .post_div_select(pst), .post_divide_ratio(odr), .aux_out_select(axs),
      .duty_thresh_half(dty), .xtal_load_sel(xls));
   scs_monitor u_scs_monitor (.clk(clk), .rst(rst), .sclk(lk.sclk), .sdata(lk.sdata),
      .strobe(lk.strobe), .powerdown_tristate_n(lk.powerdown_tristate_n));

   task automatic report_and_stop();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic near(input int v, input int e);
      chk(32'(v + 2 >= e && v <= e + 2), 32'h1);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Single AHB-Lite transfer; read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      n = 0;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 20) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   // Load word, start, optionally overwrite while busy, wait for idle
   task automatic prog(input logic [23:0] w, input logic [31:0] ctl, input bit spoil);
      int n;
      ahb(1'b1, REG_WORD, {8'h00, w});
      ahb(1'b1, REG_CTRL, ctl);
      if (spoil) ahb(1'b1, REG_WORD, 32'h0);
      cyc(4);
      n = 0;
      do begin ahb(1'b0, REG_STATUS, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         error_cnt++;
         report_and_stop();
      end
      cyc(4);
   endtask
   task automatic fields(input logic [23:0] w);
      chk({xls, dty, axs, pst, fbw, inw}, w);
   endtask
   // Count output edges over 40 clk
   task automatic watch(output int m, output int a);
      logic pm, pa;
      m = 0;
      a = 0;
      pm = mclk;
      pa = aclk;
      repeat (40) begin
         cyc(1);
         if (mclk !== pm) m++;
         if (aclk !== pa) a++;
         pm = mclk;
         pa = aclk;
      end
   endtask

   task automatic t_reset();
      int m, a;
      fields(DEFAULT_WORD);
      chk({byp, lck, odr}, {2'h3, 4'h2});
      watch(m, a);
      near(m, 20);
      near(a, 20);
      ahb(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_post();
      logic [3:0] rt [8] = '{4'hA, 4'h2, 4'h8, 4'h4, 4'h5, 4'h7, 4'h3, 4'h6};
      logic [23:0] w;
      for (int s = 0; s < 8; s++) begin
         w = {2'h0, 1'h1, AUX_MAIN_HALF, 3'(s), 9'h004, 7'h01};
         prog(w, 32'h3, 1'b0);
         fields(w);
         chk({byp, odr}, {1'b0, rt[s]});
         chk(lck, 1'b0);
         cyc(30);
         chk(lck, 1'b1);
      end
   endtask
   task automatic t_aux();
      int m, a;
      int ex [4] = '{20, 10, 0, 8};
      for (int s = 0; s < 4; s++) begin
         prog({2'h0, 1'h1, 2'(s), 3'h0, 9'h004, 7'h01}, 32'h3, 1'b0);
         watch(m, a);
         near(a, ex[s]);
         near(m, 16);
         if (s == 2) chk(aclk, 1'b0);
      end
   endtask
   task automatic t_bypass();
      int m, a;
      prog({2'h0, 1'h1, AUX_OFF, 3'h1, 9'h004, IN_DIV_BYPASS}, 32'h3, 1'b0);
      chk({byp, lck}, 2'h3);
      watch(m, a);
      near(m, 20);
      near(a, 20);
   endtask
   task automatic t_busy();
      logic [23:0] w;
      w = {2'h0, 1'h0, AUX_REF_HALF, 3'h5, 9'h1FF, 7'h7F};
      prog(w, 32'h3, 1'b1);
      fields(w);
      ahb(1'b0, REG_WORD, 32'h0);
      chk(rd, {8'h00, w});
   endtask
   task automatic t_pdn();
      logic [23:0] w;
      w = {2'h0, 1'h1, AUX_REF, 3'h6, 9'h0A5, 7'h3C};
      ahb(1'b1, REG_CTRL, 32'h0);
      cyc(4);
      chk({pdn, moe, aoe, mclk, aclk}, 5'h10);
      prog(w, 32'h1, 1'b0);
      fields(w);
      ahb(1'b1, REG_CTRL, 32'h2);
      cyc(4);
      chk({pdn, moe, aoe}, 3'h3);
      fields(w);
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      t_reset();
      t_post();
      t_aux();
      t_bypass();
      t_busy();
      t_pdn();
      report_and_stop();
   end
endmodule

//--- hw/scs_dev.sv
// Purpose: Device end, config shift path, latch and clock outputs
// Assumes: Pins asynchronous to clk, sampled by two flip-flops
// Notes: Clock outputs are a behavioural model, rate below clk/2
`timescale 1ns/1ns
module scs_dev
   import scs_pkg::*;
#(
   parameter bit HAS_DEFAULTS = 1'b1,
   parameter int LOCK_CYC = LOCK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   scs_if.dev link,
   input wire logic crystal_in_pin,
   output logic crystal_out_pin,
   output logic main_clock_out,
   output logic main_clock_oe,
   output logic aux_clock_out,
   output logic aux_clock_oe,
   output logic pll_bypass,
   output logic powered_down,
   output logic pll_locked,
   output logic [6:0] input_divider_word,
   output logic [8:0] feedback_divider_word,
   output logic [2:0] post_div_select,
   output logic [3:0] post_divide_ratio,
   output logic [1:0] aux_out_select,
   output logic duty_thresh_half,
   output logic [1:0] xtal_load_sel
);
   initial begin
      if (LOCK_CYC < 1 || LOCK_CYC >= (1 << 18)) begin
         $error("LOCK_CYC out of range");
      end
   end

   localparam logic [23:0] START_WORD = HAS_DEFAULTS ? DEFAULT_WORD : RANDOM_WORD;

   // Post-divider lookup
   function automatic logic [3:0] od_of(input logic [2:0] sel);
      logic [3:0] r;
      r = 4'hA;
      case (sel)
         3'h0: r = 4'hA;
         3'h1: r = 4'h2;
         3'h2: r = 4'h8;
         3'h3: r = 4'h4;
         3'h4: r = 4'h5;
         3'h5: r = 4'h7;
         3'h6: r = 4'h3;
         default: r = 4'h6;
      endcase
      return r;
   endfunction

   // Two-stage synchronisers for the five pin inputs
   logic [4:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
   always_comb begin
      nxt_sync1 = {crystal_in_pin, link.powerdown_tristate_n, link.strobe,
                   link.sdata, link.sclk};
      nxt_sync2 = sync1_ff;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 5'h08;
         sync2_ff <= 5'h08;
      end else if (ce) begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
      end
   end

   logic sclk_s, data_s, strobe_s, pdn_n_s, ref_s;
   assign {ref_s, pdn_n_s, strobe_s, data_s, sclk_s} = sync2_ff;

   // Shift path and configuration latch
   logic sclk_d_ff, nxt_sclk_d;
   logic [23:0] shift_ff, nxt_shift, cfg_ff, nxt_cfg;
   logic sclk_rise;
   assign sclk_rise = sclk_s & ~sclk_d_ff;
   always_comb begin
      nxt_sclk_d = sclk_s;
      nxt_shift = shift_ff;
      nxt_cfg = cfg_ff;
      if (sclk_rise) begin
         nxt_shift = {shift_ff[22:0], data_s};
      end
      // Transparent while strobe high, so shifting then alters outputs
      if (strobe_s) begin
         nxt_cfg = nxt_shift;
      end
   end
   // Power-down never clears the latch; only power-up reset does
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_d_ff <= 1'b0;
         shift_ff <= 24'h000000;
         cfg_ff <= START_WORD;
      end else if (ce) begin
         sclk_d_ff <= nxt_sclk_d;
         shift_ff <= nxt_shift;
         cfg_ff <= nxt_cfg;
      end
   end

   // Field decode of the active word
   always_comb begin
      xtal_load_sel = cfg_ff[XLOAD_MSB:XLOAD_LSB];
      duty_thresh_half = cfg_ff[DUTY_BIT];
      aux_out_select = cfg_ff[AUX_MSB:AUX_LSB];
      post_div_select = cfg_ff[POST_MSB:POST_LSB];
      feedback_divider_word = cfg_ff[FB_MSB:FB_LSB];
      input_divider_word = cfg_ff[IN_MSB:IN_LSB];
      post_divide_ratio = od_of(cfg_ff[POST_MSB:POST_LSB]);
      pll_bypass = (cfg_ff[IN_MSB:IN_LSB] == IN_DIV_BYPASS);
      powered_down = ~pdn_n_s;
   end

   // Frequency ratio terms: num is 4*(V+8), the rate's factor 2 times two toggles a period
   logic [11:0] ratio_num;
   logic [10:0] ratio_den;
   always_comb begin
      ratio_num = {10'(feedback_divider_word) + 10'(FB_OFFSET), 2'h0};
      ratio_den = 11'((8'(input_divider_word) + 8'(IN_OFFSET)) * post_divide_ratio);
   end

   // Settling timer restarts on every change of the active word
   logic [17:0] lock_cnt_ff, nxt_lock_cnt;
   logic [23:0] cfg_d_ff, nxt_cfg_d;
   always_comb begin
      nxt_cfg_d = cfg_ff;
      nxt_lock_cnt = lock_cnt_ff;
      if (cfg_ff != cfg_d_ff || powered_down) begin
         nxt_lock_cnt = 18'(LOCK_CYC);
      end else if (lock_cnt_ff != 18'h00000) begin
         nxt_lock_cnt = lock_cnt_ff - 18'h00001;
      end
      pll_locked = pll_bypass || (lock_cnt_ff == 18'h00000);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_d_ff <= START_WORD;
         lock_cnt_ff <= 18'h00000;
      end else if (ce) begin
         cfg_d_ff <= nxt_cfg_d;
         lock_cnt_ff <= nxt_lock_cnt;
      end
   end

   // Main clock: ref rises add num, each clk with acc at least den drains one den and toggles
   logic ref_d_ff, nxt_ref_d, ref_rise;
   logic [15:0] acc_ff, nxt_acc;
   logic main_ff, nxt_main, ref_half_ff, nxt_ref_half, main_half_ff, nxt_main_half;
   logic aux_ff, nxt_aux;
   assign ref_rise = ref_s & ~ref_d_ff;
   always_comb begin
      nxt_ref_d = ref_s;
      nxt_acc = acc_ff;
      nxt_main = main_ff;
      nxt_ref_half = ref_half_ff;
      nxt_main_half = main_half_ff;
      if (ref_rise) begin
         nxt_ref_half = ~ref_half_ff;
      end
      if (pll_bypass) begin
         nxt_acc = 16'h0000;
         nxt_main = ref_s;
      end else if (!powered_down) begin
         // Two toggles per output period, so den counts half periods
         if (ref_rise) begin
            nxt_acc = acc_ff + 16'(ratio_num);
         end
         if (acc_ff >= 16'(ratio_den)) begin
            nxt_acc = nxt_acc - 16'(ratio_den);
            nxt_main = ~main_ff;
         end
      end
      if (nxt_main && !main_ff) begin
         nxt_main_half = ~main_half_ff;
      end
      case (aux_out_select)
         AUX_REF: nxt_aux = ref_s;
         AUX_REF_HALF: nxt_aux = pll_bypass ? ref_s : nxt_ref_half;
         AUX_OFF: nxt_aux = pll_bypass ? ref_s : 1'b0;
         AUX_MAIN_HALF: nxt_aux = pll_bypass ? ref_s : nxt_main_half;
         default: nxt_aux = 1'b0;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_d_ff <= 1'b0;
         acc_ff <= 16'h0000;
         main_ff <= 1'b0;
         ref_half_ff <= 1'b0;
         main_half_ff <= 1'b0;
         aux_ff <= 1'b0;
      end else if (ce) begin
         ref_d_ff <= nxt_ref_d;
         acc_ff <= nxt_acc;
         main_ff <= nxt_main;
         ref_half_ff <= nxt_ref_half;
         main_half_ff <= nxt_main_half;
         aux_ff <= nxt_aux;
      end
   end

   // Pin drive: tristated and quiet while powered down
   always_comb begin
      main_clock_oe = ~powered_down;
      aux_clock_oe = ~powered_down;
      main_clock_out = main_ff & ~powered_down;
      aux_clock_out = aux_ff & ~powered_down;
      crystal_out_pin = ~ref_s & ~powered_down;
   end
endmodule

//--- hw/scs_host.sv
// Purpose: Host end, AHB-Lite registers driving the serial link
// Assumes: Slave answers with zero wait states, always OKAY
// Notes: Start while busy is ignored
`timescale 1ns/1ns
module scs_host
   import scs_pkg::*;
#(
   parameter int HALF_CYC = SETUP_CYCLES,
   parameter int STB_CYC = STROBE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   scs_if.host link
);
   initial begin
      if (HALF_CYC < 1 || HALF_CYC > 255 || STB_CYC < 1 || STB_CYC > 255) begin
         $error("host timing parameters out of range");
      end
   end

   typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_STROBE} scs_state_t;
   scs_state_t st_ff, nxt_st;
   logic [23:0] word_ff, nxt_word, sh_ff, nxt_sh;
   logic [4:0] bit_ff, nxt_bit;
   logic [7:0] tmr_ff, nxt_tmr;
   logic pdn_n_ff, nxt_pdn_n, sclk_ff, nxt_sclk, sdata_ff, nxt_sdata, stb_ff, nxt_stb;
   logic wr_ff, nxt_wr;
   logic [7:0] wa_ff, nxt_wa;
   logic [31:0] rd_ff, nxt_rd;
   logic busy, go;

   assign busy = (st_ff != ST_IDLE);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_ff;
   assign go = wr_ff && wa_ff == REG_CTRL && hwdata[CTRL_GO] && !busy;

   // Bus slave: capture address phase, write in data phase
   always_comb begin
      logic take;
      take = hsel && hready && htrans == HTRANS_NONSEQ;
      nxt_wr = take && hwrite;
      nxt_wa = haddr[7:0];
      nxt_rd = rd_ff;
      nxt_word = word_ff;
      nxt_pdn_n = pdn_n_ff;
      if (take && !hwrite) begin
         case (haddr[7:0])
            REG_CTRL: nxt_rd = {30'h0, pdn_n_ff, 1'b0};
            REG_WORD: nxt_rd = {8'h00, word_ff};
            REG_STATUS: nxt_rd = {31'h0, busy};
            default: nxt_rd = 32'h00000000;
         endcase
      end
      if (wr_ff && wa_ff == REG_WORD && !busy) begin
         nxt_word = hwdata[23:0];
      end
      if (wr_ff && wa_ff == REG_CTRL) begin
         nxt_pdn_n = hwdata[CTRL_PDN];
      end
   end

   // Serial sequencer: 24 bits first-to-last, then strobe
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_bit = bit_ff;
      nxt_tmr = tmr_ff;
      nxt_sclk = sclk_ff;
      nxt_sdata = sdata_ff;
      nxt_stb = stb_ff;
      if (tmr_ff != 8'h00) begin
         nxt_tmr = tmr_ff - 8'h01;
      end
      case (st_ff)
         ST_IDLE: begin
            if (go) begin
               nxt_st = ST_LOW;
               nxt_sh = word_ff;
               nxt_bit = 5'h17;
               nxt_sclk = 1'b0;
               nxt_stb = 1'b0;
               nxt_sdata = word_ff[23];
               nxt_tmr = 8'(HALF_CYC - 1);
            end
         end
         ST_LOW: begin
            if (tmr_ff == 8'h00) begin
               nxt_st = ST_HIGH;
               nxt_sclk = 1'b1;
               nxt_tmr = 8'(HALF_CYC - 1);
            end
         end
         ST_HIGH: begin
            if (tmr_ff == 8'h00) begin
               nxt_sclk = 1'b0;
               nxt_tmr = 8'(HALF_CYC - 1);
               if (bit_ff == 5'h00) begin
                  nxt_st = ST_STROBE;
                  nxt_stb = 1'b1;
                  nxt_tmr = 8'(STB_CYC - 1);
               end else begin
                  nxt_st = ST_LOW;
                  nxt_bit = bit_ff - 5'h01;
                  nxt_sh = {sh_ff[22:0], 1'b0};
                  nxt_sdata = sh_ff[22];
               end
            end
         end
         ST_STROBE: begin
            if (tmr_ff == 8'h00) begin
               nxt_st = ST_IDLE;
               nxt_stb = 1'b0;
               nxt_sdata = 1'b0;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= ST_IDLE;
         word_ff <= DEFAULT_WORD;
         sh_ff <= 24'h000000;
         bit_ff <= 5'h00;
         tmr_ff <= 8'h00;
         pdn_n_ff <= CTRL_RESET[CTRL_PDN];
         sclk_ff <= 1'b0;
         sdata_ff <= 1'b0;
         stb_ff <= 1'b0;
         wr_ff <= 1'b0;
         wa_ff <= 8'h00;
         rd_ff <= 32'h00000000;
      end else if (ce) begin
         st_ff <= nxt_st;
         word_ff <= nxt_word;
         sh_ff <= nxt_sh;
         bit_ff <= nxt_bit;
         tmr_ff <= nxt_tmr;
         pdn_n_ff <= nxt_pdn_n;
         sclk_ff <= nxt_sclk;
         sdata_ff <= nxt_sdata;
         stb_ff <= nxt_stb;
         wr_ff <= nxt_wr;
         wa_ff <= nxt_wa;
         rd_ff <= nxt_rd;
      end
   end

   // Link pins straight from flip-flops
   always_comb begin
      link.sclk = sclk_ff;
      link.sdata = sdata_ff;
      link.strobe = stb_ff;
      link.powerdown_tristate_n = pdn_n_ff;
   end
endmodule

//--- hw/scs_if.sv
// Purpose: Three-wire programming link plus power-down pin
// Assumes: Host drives every wire; device only listens
// Notes: Power-down pin idles high like its pull-up
`timescale 1ns/1ns
interface scs_if;
   logic sclk;
   logic sdata;
   logic strobe;
   logic powerdown_tristate_n;
   modport dev (input sclk, input sdata, input strobe, input powerdown_tristate_n);
   modport host (output sclk, output sdata, output strobe, output powerdown_tristate_n);
endinterface

//--- hw/scs_pkg.sv
// Purpose: Shared constants for the serial clock synth config link
// Assumes: One 25 MHz system clock on both ends
// Notes: Serial word is 24 bits, first bit shifted is bit 23
// Behaviour
// - Aux select picks ref, ref/2, low, main/2
// - Post select maps to ratios 10,2,8,4,5,7,3,6
// - Power-down low tristates outputs; pulled up default
// - Single data line carries the configuration words
// - Host keeps feedback divider within 4..511
// - Host keeps input divider within 1..127
// - Input divider zero bypasses PLL, ref out
// - Defaults variant starts at multiply by one
// - No-defaults variant starts with arbitrary word
// - Main freq = in*2*(V+8)/((R+2)*OD)
// - Duty bit: 0 at 1.4 V, 1 at half supply
// - Host sets crystal load zero for clock input
// - Reprogram live, settle within 10 ms
// - Host keeps VCO and compare rates in range
// - Strobe pulse loads shifted word into latch
// - Shift clock moves data into shift path
// - 24 bits, crystal MSB first, strobe after
// - Shifting with strobe high updates latch directly
// - Programming kept across power-down
package scs_pkg;
   localparam int WORD_BITS = 24;
   // Field positions within the serial word
   localparam int XLOAD_MSB = 23;
   localparam int XLOAD_LSB = 22;
   localparam int DUTY_BIT = 21;
   localparam int AUX_MSB = 20;
   localparam int AUX_LSB = 19;
   localparam int POST_MSB = 18;
   localparam int POST_LSB = 16;
   localparam int FB_MSB = 15;
   localparam int FB_LSB = 7;
   localparam int IN_MSB = 6;
   localparam int IN_LSB = 0;
   // Bypass word: ref on both outputs, duty at half supply
   localparam logic [23:0] DEFAULT_WORD = 24'h210000;
   // Arbitrary start word for the variant without defaults
   localparam logic [23:0] RANDOM_WORD = 24'hD6A5C3;
   localparam logic [1:0] AUX_REF = 2'h0;
   localparam logic [1:0] AUX_REF_HALF = 2'h1;
   localparam logic [1:0] AUX_OFF = 2'h2;
   localparam logic [1:0] AUX_MAIN_HALF = 2'h3;
   localparam logic [6:0] IN_DIV_BYPASS = 7'h00;
   localparam logic [3:0] FB_OFFSET = 4'h8;
   localparam logic [1:0] IN_OFFSET = 2'h2;
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_HZ = 25000000;
   localparam int LOCK_TIME_MS = 10;
   localparam int LOCK_CYCLES = LOCK_TIME_MS * (CLK_HZ / 1000);
   localparam int T_SETUP_NS = 10;
   localparam int T_STROBE_NS = 40;
   localparam int SETUP_CYCLES = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYCLES = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Host register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WORD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_GO = 0;
   localparam int CTRL_PDN = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
